//--- hdl/edi_diag_ind.sv
// Indicator drive, V.54 loopbacks and V.52 pattern generator/checker for an E1 NTU.
// Assumes serial bits, bit strobe, slot flag and line conditions come from framer logic
// on the same clock; only the DTE loop-request leads arrive asynchronously.
`timescale 1ns/1ns
`include "edi_map.svh"

module edi_diag_ind #(
    parameter int unsigned EIGHTH_CYC = `EDI_EIGHTH_NS / `EDI_CLK_NS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial stream from and to the framer and DTE
    input wire logic bitStb,
    input wire logic slotActive,
    input wire logic dteTxBit,
    input wire logic lineRxBit,
    output logic lineTxBit,
    output logic dteRxBit,
    // Line conditions and DTE leads
    input wire edi_pkg::cond_s cond,
    input wire logic localLoopReqPin,
    input wire logic remoteLoopReqPin,
    // Indicators and loop command to the peer
    output edi_pkg::led_s leds,
    output logic remoteLoopCmd
);

    // ******************************
    // Time base
    // ******************************
    logic [23:0] eighthCnt_r;
    logic [2:0] phase_r;
    logic tick8;
    logic halfTick;
    logic secTick;
    assign tick8 = (eighthCnt_r == 24'(EIGHTH_CYC - 1));
    assign halfTick = tick8 && (phase_r[1:0] == 2'h3);
    assign secTick = tick8 && (phase_r == 3'h7);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eighthCnt_r <= 24'h0;
            phase_r <= 3'h0;
        end
        else if (tick8)
        begin
            eighthCnt_r <= 24'h0;
            phase_r <= phase_r + 3'h1;
        end
        else
            eighthCnt_r <= eighthCnt_r + 24'h1;
    end

    // ******************************
    // Register file
    // ******************************
    edi_pkg::ctrl_s ctrlR;
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic addrPh;
    logic [31:0] statWord;
    logic [31:0] ctrlWord;
    logic bitErr_r;
    logic loopHold_r;
    logic localAct;
    logic remoteAct;
    edi_pkg::chk_e chkState_r;
    assign addrPh = hsel && htrans[1] && hready;
    // Fields placed by the map, not by the struct's packing
    always_comb
    begin
        ctrlWord = 32'h0;
        ctrlWord[`EDI_B_LLOOP] = ctrlR.lLoop;
        ctrlWord[`EDI_B_RLOOP] = ctrlR.rLoop;
        ctrlWord[`EDI_B_PATEN] = ctrlR.patEn;
        ctrlWord[`EDI_B_PATSEL +: 2] = ctrlR.patSel;
        ctrlWord[`EDI_B_ERRINS] = ctrlR.errIns;
        ctrlWord[`EDI_B_UNFR] = ctrlR.unframed;
        ctrlWord[`EDI_B_TOSEL +: 4] = ctrlR.toSel;
        statWord = 32'h0;
        statWord[`EDI_S_LOCK] = (chkState_r == edi_pkg::LOCKED);
        statWord[`EDI_S_BERR] = bitErr_r;
        statWord[`EDI_S_OK] = (chkState_r == edi_pkg::LOCKED) && !bitErr_r;
        statWord[`EDI_S_LACT] = localAct;
        statWord[`EDI_S_RACT] = remoteAct;
        statWord[`EDI_S_HOLD] = loopHold_r;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            // Zero wait states; read data is staged in the address phase
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_r <= addrPh && hwrite;
            if (addrPh)
                wrAddr_r <= haddr[7:0];
            if (addrPh && !hwrite)
            begin
                if (haddr[7:0] == `EDI_OFS_CTRL)
                    hrdata <= ctrlWord;
                else if (haddr[7:0] == `EDI_OFS_STAT)
                    hrdata <= statWord;
                else
                    hrdata <= 32'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrlR.lLoop <= 1'(`EDI_CTRL_RST >> `EDI_B_LLOOP);
            ctrlR.rLoop <= 1'(`EDI_CTRL_RST >> `EDI_B_RLOOP);
            ctrlR.patEn <= 1'(`EDI_CTRL_RST >> `EDI_B_PATEN);
            ctrlR.patSel <= edi_pkg::pat_e'(2'(`EDI_CTRL_RST >> `EDI_B_PATSEL));
            ctrlR.errIns <= 1'(`EDI_CTRL_RST >> `EDI_B_ERRINS);
            ctrlR.unframed <= 1'(`EDI_CTRL_RST >> `EDI_B_UNFR);
            ctrlR.toSel <= 4'(`EDI_CTRL_RST >> `EDI_B_TOSEL);
        end
        else if (wrPend_r && wrAddr_r == `EDI_OFS_CTRL)
        begin
            ctrlR.lLoop <= hwdata[`EDI_B_LLOOP];
            ctrlR.rLoop <= hwdata[`EDI_B_RLOOP];
            ctrlR.patEn <= hwdata[`EDI_B_PATEN];
            ctrlR.patSel <= edi_pkg::pat_e'(hwdata[`EDI_B_PATSEL +: 2]);
            ctrlR.errIns <= hwdata[`EDI_B_ERRINS];
            ctrlR.unframed <= hwdata[`EDI_B_UNFR];
            ctrlR.toSel <= hwdata[`EDI_B_TOSEL +: 4];
        end
    end

    // ******************************
    // Loop control and timeout
    // ******************************
    logic [1:0] llSync_r;
    logic [1:0] rlSync_r;
    logic [13:0] secCnt_r;
    logic [13:0] toLimit;
    logic toExpire;
    logic llReq;
    logic rlReq;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            llSync_r <= 2'h0;
            rlSync_r <= 2'h0;
        end
        else
        begin
            llSync_r <= {llSync_r[0], localLoopReqPin};
            rlSync_r <= {rlSync_r[0], remoteLoopReqPin};
        end
    end

    assign llReq = ctrlR.lLoop || llSync_r[1];
    assign rlReq = ctrlR.rLoop || rlSync_r[1];
    // Local loop wins if both are asked for; the echo path cannot serve both
    assign localAct = llReq && !loopHold_r;
    assign remoteAct = rlReq && !loopHold_r && !localAct;

    always_comb
    begin
        case (ctrlR.toSel)
            4'h0: toLimit = `EDI_TO_M0 * `EDI_SEC_PER_MIN;
            4'h1: toLimit = `EDI_TO_M1 * `EDI_SEC_PER_MIN;
            4'h2: toLimit = `EDI_TO_M2 * `EDI_SEC_PER_MIN;
            4'h3: toLimit = `EDI_TO_M3 * `EDI_SEC_PER_MIN;
            4'h4: toLimit = `EDI_TO_M4 * `EDI_SEC_PER_MIN;
            4'h5: toLimit = `EDI_TO_M5 * `EDI_SEC_PER_MIN;
            4'h6: toLimit = `EDI_TO_M6 * `EDI_SEC_PER_MIN;
            4'h7: toLimit = `EDI_TO_M7 * `EDI_SEC_PER_MIN;
            4'h8: toLimit = `EDI_TO_M8 * `EDI_SEC_PER_MIN;
            default: toLimit = 14'h0;
        endcase
    end
    assign toExpire = (toLimit != 14'h0) && (localAct || remoteAct) && (secCnt_r >= toLimit);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secCnt_r <= 14'h0;
            loopHold_r <= 1'b0;
        end
        else
        begin
            if (!(localAct || remoteAct))
                secCnt_r <= 14'h0;
            else if (secTick && secCnt_r != 14'h3fff)
                secCnt_r <= secCnt_r + 14'h1;
            // Hold off until every request is withdrawn, so a stuck lead cannot re-enter
            if (toExpire)
                loopHold_r <= 1'b1;
            else if (!llReq && !rlReq)
                loopHold_r <= 1'b0;
        end
    end

    // ******************************
    // Pattern generator
    // ******************************
    logic [19:0] gen_r;
    logic [4:0] genZ_r;
    logic genFb;
    logic genBit;
    logic insPend_r;
    logic txPat;
    logic txNow;

    function automatic logic tapFb(input edi_pkg::pat_e sel, input logic [19:0] s);
        case (sel)
            edi_pkg::PAT511: tapFb = s[8] ^ s[4];
            edi_pkg::PAT2047: tapFb = s[10] ^ s[8];
            default: tapFb = s[19] ^ s[16];
        endcase
    endfunction

    assign genFb = tapFb(ctrlR.patSel, gen_r);
    // Long zero runs are forced to one for the 2^20 sequence only
    assign genBit = (ctrlR.patSel == edi_pkg::PATQRSS && genZ_r >= `EDI_ZRUN) ? 1'b1 : genFb;
    assign txPat = genBit ^ insPend_r;
    assign txNow = (ctrlR.patEn && slotActive) ? txPat : dteTxBit;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gen_r <= 20'hfffff;
            genZ_r <= 5'h0;
        end
        else if (bitStb && slotActive)
        begin
            gen_r <= {gen_r[18:0], genFb};
            genZ_r <= genFb ? 5'h0 : ((genZ_r == 5'h1f) ? genZ_r : genZ_r + 5'h1);
        end
    end

    // One corrupted bit per second; a new second wins over consumption
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            insPend_r <= 1'b0;
        else if (secTick && ctrlR.errIns && ctrlR.patEn)
            insPend_r <= 1'b1;
        else if (bitStb && slotActive)
            insPend_r <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lineTxBit <= 1'b0;
            dteRxBit <= 1'b0;
        end
        else if (bitStb)
        begin
            lineTxBit <= txNow;
            dteRxBit <= localAct ? dteTxBit : lineRxBit;
        end
    end

    // ******************************
    // Pattern checker
    // ******************************
    logic [19:0] chk_r;
    logic [4:0] chkZ_r;
    logic chkIn;
    logic chkSupp;
    logic chkFeed;
    logic mism;
    logic chkStep;
    logic [5:0] runCnt_r;
    logic [7:0] winCnt_r;
    logic [2:0] errHold_r;
    logic hitErr;

    // In local loop the pattern is looped inside the unit
    assign chkIn = localAct ? txPat : lineRxBit;
    assign chkStep = ctrlR.patEn && bitStb && slotActive;
    assign chkSupp = (ctrlR.patSel == edi_pkg::PATQRSS) && (chkZ_r >= `EDI_ZRUN);
    // Forced ones stay out of the register, so it keeps mirroring the generator
    assign chkFeed = chkSupp ? tapFb(ctrlR.patSel, chk_r) : chkIn;
    assign mism = (tapFb(ctrlR.patSel, chk_r) != chkIn) && !chkSupp;
    assign hitErr = chkStep && chkState_r == edi_pkg::LOCKED && mism;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chk_r <= 20'h0;
            chkZ_r <= 5'h0;
        end
        else if (chkStep)
        begin
            chk_r <= {chk_r[18:0], chkFeed};
            chkZ_r <= chkFeed ? 5'h0 : ((chkZ_r == 5'h1f) ? chkZ_r : chkZ_r + 5'h1);
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chkState_r <= edi_pkg::HUNT;
            runCnt_r <= 6'h0;
            winCnt_r <= 8'h0;
        end
        else if (!ctrlR.patEn)
        begin
            chkState_r <= edi_pkg::HUNT;
            runCnt_r <= 6'h0;
        end
        else if (chkStep)
        begin
            case (chkState_r)
                edi_pkg::HUNT:
                begin
                    runCnt_r <= mism ? 6'h0 : runCnt_r + 6'h1;
                    if (!mism && runCnt_r == `EDI_SYNC_BITS - 6'h1)
                    begin
                        chkState_r <= edi_pkg::LOCKED;
                        runCnt_r <= 6'h0;
                        winCnt_r <= 8'h0;
                    end
                end
                edi_pkg::LOCKED:
                begin
                    winCnt_r <= winCnt_r + 8'h1;
                    if (winCnt_r == 8'hff)
                        runCnt_r <= 6'h0;
                    else if (mism)
                        runCnt_r <= runCnt_r + 6'h1;
                    if (mism && runCnt_r == `EDI_LOSS_ERRS - 6'h1)
                    begin
                        chkState_r <= edi_pkg::HUNT;
                        runCnt_r <= 6'h0;
                    end
                end
                default: chkState_r <= edi_pkg::HUNT;
            endcase
        end
    end

    // Error result is sticky; a new error wins over a write-one clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            bitErr_r <= 1'b0;
        else if (hitErr)
            bitErr_r <= 1'b1;
        else if (wrPend_r && wrAddr_r == `EDI_OFS_STAT && hwdata[`EDI_S_BERR])
            bitErr_r <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            errHold_r <= 3'h0;
        else if (hitErr)
            errHold_r <= `EDI_HOLD_TICKS;
        else if (tick8 && errHold_r != 3'h0)
            errHold_r <= errHold_r - 3'h1;
    end

    // ******************************
    // Indicators
    // ******************************
    logic alarmAct;
    logic condErr;
    assign alarmAct = cond.ais || cond.rai || cond.oof || cond.frameSyncLoss;
    assign condErr = cond.frmBitErr || cond.excZeros || cond.slip || cond.sevErr;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            leds <= '0;
            remoteLoopCmd <= 1'b0;
        end
        else
        begin
            leds.power <= 1'b1;
            leds.txAct <= bitStb ? (slotActive && txNow) : (leds.txAct && slotActive);
            leds.rxAct <= bitStb ? (slotActive && lineRxBit) : (leds.rxAct && slotActive);
            leds.syncFail <= ctrlR.unframed ? cond.txClkFail : (cond.frameSyncLoss || cond.sigLoss);
            if (!alarmAct)
                leds.alarm <= 1'b0;
            else if (halfTick)
                leds.alarm <= !leds.alarm;
            leds.fault <= condErr || (errHold_r != 3'h0)
                || (ctrlR.patEn && chkState_r == edi_pkg::HUNT);
            // First second of a remote loop is the command phase to the peer
            if (ctrlR.patEn || (remoteAct && secCnt_r == 14'h0))
                leds.testMode <= 1'b1;
            else if (remoteAct)
                leds.testMode <= (phase_r != 3'h0);
            else if (localAct)
                leds.testMode <= (phase_r == 3'h0);
            else
                leds.testMode <= 1'b0;
            remoteLoopCmd <= remoteAct;
        end
    end

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence sBitIn;
        bitStb && slotActive;
    endsequence
    sequence sQuiet;
        !slotActive;
    endsequence

    chk_tx_follow: assert property (sBitIn |=> leds.txAct == lineTxBit)
        else $error("tx light differs from sent bit");
    chk_tx_dark: assert property (sQuiet |=> !leds.txAct)
        else $error("tx light on in idle slot");
    chk_rx_follow: assert property (sBitIn |=> leds.rxAct == $past(lineRxBit))
        else $error("rx light differs from received bit");
    chk_rx_dark: assert property (sQuiet |=> !leds.rxAct)
        else $error("rx light on in idle slot");
    chk_sync_src: assert property (##1 leds.syncFail == ($past(ctrlR.unframed) ? $past(cond.txClkFail)
        : ($past(cond.frameSyncLoss) || $past(cond.sigLoss))))
        else $error("sync light from wrong source");
    chk_alarm_quiet: assert property (!alarmAct ##1 !alarmAct |-> !leds.alarm)
        else $error("alarm light without alarm");
    chk_fault_hunt: assert property (ctrlR.patEn && chkState_r == edi_pkg::HUNT |=> leds.fault)
        else $error("fault light off while unlocked");
    chk_local_echo: assert property (localAct && bitStb |=> dteRxBit == $past(dteTxBit))
        else $error("local loop echo lost");
    chk_loop_expire: assert property (toExpire |=> !localAct && !remoteAct)
        else $error("loop survives timeout");
    chk_err_insert: assert property (((insPend_r && ctrlR.patEn) and sBitIn) |=> lineTxBit == !$past(genBit))
        else $error("inserted error not sent");

endmodule // edi_diag_ind

//--- hdl/edi_map.svh
// Register map, field positions, reset values and timing figures for the diagnostic block.
// Assumes a 25 MHz system clock and a byte-addressed AHB-Lite window.
`ifndef EDI_MAP_SVH
`define EDI_MAP_SVH
`define EDI_OFS_CTRL 8'h00
`define EDI_OFS_STAT 8'h04
`define EDI_CTRL_RST 32'h0000_0300
`define EDI_B_LLOOP 0
`define EDI_B_RLOOP 1
`define EDI_B_PATEN 2
`define EDI_B_PATSEL 3
`define EDI_B_ERRINS 5
`define EDI_B_UNFR 6
`define EDI_B_TOSEL 8
`define EDI_S_LOCK 0
`define EDI_S_BERR 1
`define EDI_S_OK 2
`define EDI_S_LACT 3
`define EDI_S_RACT 4
`define EDI_S_HOLD 5
`define EDI_CLK_NS 40
`define EDI_EIGHTH_NS 125000000
`define EDI_TO_M0 14'd5
`define EDI_TO_M1 14'd10
`define EDI_TO_M2 14'd15
`define EDI_TO_M3 14'd30
`define EDI_TO_M4 14'd45
`define EDI_TO_M5 14'd60
`define EDI_TO_M6 14'd90
`define EDI_TO_M7 14'd120
`define EDI_TO_M8 14'd180
`define EDI_SEC_PER_MIN 14'd60
`define EDI_SYNC_BITS 6'h20
`define EDI_LOSS_ERRS 6'h20
`define EDI_ZRUN 5'h0e
`define EDI_HOLD_TICKS 3'h4
`endif

//--- hdl/edi_pkg.sv
// Types shared by the diagnostic and indicator block.
// Assumes nothing beyond the constants header.
package edi_pkg;
    typedef enum logic [1:0] {PAT511, PAT2047, PATQRSS} pat_e;
    typedef enum logic {HUNT, LOCKED} chk_e;
    typedef struct packed {
        logic [3:0] toSel;
        logic unframed;
        logic errIns;
        pat_e patSel;
        logic patEn;
        logic rLoop;
        logic lLoop;
    } ctrl_s;
    typedef struct packed {
        logic frameSyncLoss;
        logic sigLoss;
        logic txClkFail;
        logic ais;
        logic rai;
        logic oof;
        logic frmBitErr;
        logic excZeros;
        logic slip;
        logic sevErr;
    } cond_s;
    typedef struct packed {
        logic power;
        logic txAct;
        logic rxAct;
        logic syncFail;
        logic alarm;
        logic fault;
        logic testMode;
    } led_s;
endpackage

//--- test/edi_peer_model.sv
// Far-end peer unit, reduced to its V.54 loop behaviour on the line.
// Assumes it shares the clock and bit strobe of the block under test.
`timescale 1ns/1ns
module edi_peer_model (
    // Clock, reset and bit timing
    input wire logic clock,
    input wire logic rst_b,
    input wire logic bitStb,
    // Line side
    input wire logic lineTxBit,
    input wire logic remoteLoopCmd,
    output logic lineRxBit
);
    // Idle traffic alternates so that a stale bit never passes for an echo
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            lineRxBit <= 1'b0;
        else if (bitStb)
            lineRxBit <= remoteLoopCmd ? lineTxBit : ~lineRxBit;
    end
endmodule // edi_peer_model

//--- test/e1_ntu_diag_indicator_control_tb.sv
// Self-checking bench for the diagnostic and indicator block.
// Assumes the peer model closes the line and a lone AHB-Lite slave.
`timescale 1ns/1ns
`include "edi_map.svh"
module e1_ntu_diag_indicator_control_tb;
    // Short eighth-second so seconds and loop timeouts fit in one run
    localparam int EC = 8;
    localparam int SEC = 8 * EC;
    localparam logic [7:0] RC = `EDI_OFS_CTRL;
    localparam logic [7:0] RS = `EDI_OFS_STAT;
    localparam logic [31:0] CT = `EDI_CTRL_RST;
    logic clock, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic bitStb, slotActive, dteTxBit, lineRxBit, lineTxBit, dteRxBit, rxSeen;
    logic localLoopReqPin, remoteLoopReqPin, remoteLoopCmd;
    edi_pkg::cond_s cond;
    edi_pkg::led_s leds;
    int failures, n_checks, ones, flips;
    assign hready = hreadyout;

    edi_diag_ind #(.EIGHTH_CYC(EC)) uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bitStb(bitStb),
        .slotActive(slotActive), .dteTxBit(dteTxBit), .lineRxBit(lineRxBit), .lineTxBit(lineTxBit),
        .dteRxBit(dteRxBit), .cond(cond), .localLoopReqPin(localLoopReqPin),
        .remoteLoopReqPin(remoteLoopReqPin), .leds(leds), .remoteLoopCmd(remoteLoopCmd));
    edi_peer_model peer (.clock(clock), .rst_b(rst_b), .bitStb(bitStb), .lineTxBit(lineTxBit),
        .remoteLoopCmd(remoteLoopCmd), .lineRxBit(lineRxBit));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Waits as long as the slave stalls; only the watchdog ends a hung transfer
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask

    // One serial bit; rxSeen is the line bit the block sampled
    task automatic sbit(input logic d, input logic act);
        @(posedge clock);
        bitStb <= 1'b1;
        slotActive <= act;
        dteTxBit <= d;
        @(posedge clock);
        rxSeen = lineRxBit;
        bitStb <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic setc(input edi_pkg::cond_s v);
        @(posedge clock);
        cond <= v;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // One second of test-light on cycles and alarm-light changes
    task automatic span();
        logic pa;
        ones = 0;
        flips = 0;
        pa = leds.alarm;
        repeat (SEC)
        begin
            @(posedge clock);
            #1;
            ones += leds.testMode;
            flips += (leds.alarm !== pa);
            pa = leds.alarm;
        end
    endtask

    task automatic pins(input logic l, input logic r);
        @(posedge clock);
        localLoopReqPin <= l;
        remoteLoopReqPin <= r;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk({leds.power, hresp}, 2'b10, "power");
        ahb(1'b0, RC, 0);
        chk(rd, CT, "ctrl reset");
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        ahb(1'b0, 8'h10, 0);
        chk(rd, 0, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_act();
        logic act;
        for (int i = 0; i < 8; i++)
        begin
            act = (i < 5);
            sbit(i[0], act);
            chk(leds.txAct, act & i[0], "txAct");
            chk(leds.rxAct, act & rxSeen, "rxAct");
        end
        $display("test activity done");
    endtask

    task automatic t_cond();
        int al[4] = '{9, 6, 5, 4};
        foreach (al[k])
        begin
            setc(edi_pkg::cond_s'(10'h1 << al[k]));
            span();
            chk(flips, 2, "alarm blink");
            chk(leds.syncFail, al[k] == 9, "frame loss");
        end
        setc('0);
        chk(leds.alarm, 0, "alarm off");
        for (int b = 0; b < 4; b++)
        begin
            setc(edi_pkg::cond_s'(10'h1 << b));
            chk(leds.fault, 1, "fault cond");
        end
        setc('0);
        chk(leds.fault, 0, "fault clear");
        setc(edi_pkg::cond_s'(10'h100));
        chk(leds.syncFail, 1, "signal loss");
        ahb(1'b1, RC, CT | (32'h1 << `EDI_B_UNFR));
        setc(edi_pkg::cond_s'(10'h300));
        chk(leds.syncFail, 0, "unframed");
        setc(edi_pkg::cond_s'(10'h080));
        chk(leds.syncFail, 1, "tx clock");
        ahb(1'b1, RC, CT);
        setc('0);
        chk(leds.syncFail, 0, "sync ok");
        $display("test conditions done");
    endtask

    task automatic t_loops();
        logic [11:0] h;
        h = 12'h5a3;
        pins(1'b1, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            sbit(h[i], 1'b1);
            chk(dteRxBit, h[i], "local echo");
        end
        ahb(1'b0, RS, 0);
        chk(rd[`EDI_S_LACT], 1, "local active");
        span();
        chk(ones, EC, "test blink on");
        pins(1'b0, 1'b0);
        ahb(1'b1, RC, CT | 32'h2);
        for (int i = 0; i < 12; i++)
        begin
            sbit(h[i], 1'b1);
            chk(lineTxBit, h[i], "to line");
            if (i > 3)
                chk(dteRxBit, h[i - 2], "remote echo");
        end
        chk({remoteLoopCmd, leds.testMode}, 2'b11, "remote cmd");
        repeat (3) span();
        chk(ones, SEC - EC, "test blink off");
        ahb(1'b1, RC, CT);
        pins(1'b0, 1'b1);
        chk(remoteLoopCmd, 1, "remote pin");
        pins(1'b0, 1'b0);
        chk(remoteLoopCmd, 0, "remote off");
        $display("test loops done");
    endtask

    task automatic t_pat();
        int nf;
        nf = 0;
        for (int s = 0; s < 3; s++)
        begin
            ahb(1'b1, RC, CT | 32'h5 | (s << `EDI_B_PATSEL));
            sbit(1'b0, 1'b1);
            if (s == 0)
                chk(leds.fault, 1, "fault hunting");
            chk(leds.testMode, 1, "test steady");
            repeat (120) sbit(1'b0, 1'b1);
            ahb(1'b1, RS, 32'h2);
            repeat (20) sbit(1'b0, 1'b1);
            ahb(1'b0, RS, 0);
            chk(rd[3:0], 4'hd, "pattern ok");
            chk(leds.fault, 0, "fault off");
        end
        ahb(1'b1, RC, CT | 32'h35 | (2 << `EDI_B_PATSEL));
        ahb(1'b1, RS, 32'h2);
        repeat (45)
        begin
            sbit(1'b0, 1'b1);
            nf += leds.fault;
        end
        chk(nf > 0 && nf < 45, 1, "fault flash");
        ahb(1'b0, RS, 0);
        chk(rd[2:0], 3'b011, "errors seen");
        ahb(1'b1, RC, CT);
        $display("test pattern done");
    endtask

    task automatic t_tmo();
        int n;
        n = 0;
        ahb(1'b1, RC, 32'h2);
        repeat (2) @(posedge clock);
        while (remoteLoopCmd === 1'b1 && n++ < 25000) @(posedge clock);
        n -= 19200;
        chk(n > -SEC && n < SEC, 1, "loop timeout");
        ahb(1'b0, RS, 0);
        chk(rd[`EDI_S_HOLD], 1, "loop hold");
        ahb(1'b1, RC, CT);
        $display("test timeout done");
    endtask

    initial
    begin
        failures = 0;
        n_checks = 0;
        rst_b = 1'b0;
        {hsel, hwrite, bitStb, slotActive, dteTxBit, localLoopReqPin, remoteLoopReqPin} = '0;
        {haddr, hwdata} = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        cond = '0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        t_reset();
        t_act();
        t_cond();
        t_loops();
        t_pat();
        t_tmo();
        test_done();
    end

    // Whole run is near 21500 cycles
    initial
    begin
        #(60000 * 40);
        failures++;
        test_done();
    end
endmodule // e1_ntu_diag_indicator_control_tb
